// ### design/hbwu_pkg.sv
// Purpose: Shared constants and types for the breakpoint and watchpoint unit.
// Assumes: Registers are addressed by index; byte address is four times the index.
// Notes:   Bank bases are multiples of four, so index bits 7:2 name the bank.
package hbwu_pkg;
  localparam int NSLOT    = 4;
  localparam int DATA_W   = 32;
  localparam int THR_W    = 3;
  localparam int MAX_THR  = 8;

  // Register indices.
  localparam logic [7:0] IDX_IB_ADDR = 8'h30;
  localparam logic [7:0] IDX_IB_CTRL = 8'h40;
  localparam logic [7:0] IDX_DW_A1   = 8'h50;
  localparam logic [7:0] IDX_DW_A2   = 8'h60;
  localparam logic [7:0] IDX_DW_CTRL = 8'h70;
  localparam logic [7:0] IDX_RW_MASK = 8'h80;
  localparam logic [7:0] IDX_RW_VAL  = 8'h90;
  localparam logic [7:0] IDX_RW_CTRL = 8'h9C;
  localparam logic [7:0] IDX_DBG_TY  = 8'h15;
  localparam logic [7:0] IDX_DBG_DAT = 8'h16;

  // Control register fields.
  localparam int B_EN     = 0;
  localparam int B_SEL    = 1;
  localparam int B_LOAD   = 2;
  localparam int B_THR_LO = 16;

  localparam logic [31:0] MASK_IB_CTRL = 32'h00FF_0003;
  localparam logic [31:0] MASK_DW_CTRL = 32'h00FF_0007;
  localparam logic [31:0] MASK_RW_CTRL = 32'h00FF_0003;
  localparam logic [31:0] MASK_DBG_TY  = 32'h0003_FF07;
  localparam logic [31:0] RST_CTRL     = 32'h0000_0000;

  // Debug interrupt type fields and cause codes.
  localparam int TY_NUM_LO = 16;
  localparam int TY_THR_LO = 8;
  localparam logic [2:0] CAUSE_IB = 3'h3;
  localparam logic [2:0] CAUSE_DW = 3'h4;
  localparam logic [2:0] CAUSE_RW = 3'h5;

  typedef enum logic [1:0] {HBWU_INSTR, HBWU_DATA, HBWU_RES} hbwu_kind_e;
  typedef enum logic {BUS_IDLE, BUS_ACK} hbwu_bus_e;

  // One pipeline event: a program counter, an effective address or a resource id.
  typedef struct packed {
    logic              valid;
    logic              load;
    logic [THR_W-1:0]  thread;
    logic [DATA_W-1:0] value;
  } hbwu_ev_s;
endpackage : hbwu_pkg

// ### design/hbwu_cmp.sv
// Purpose: One breakpoint or watchpoint comparator of a given kind.
// Assumes: Event and registers are stable within the cycle; output is combinational.
// Notes:   For resource kind, reg_a is the mask and reg_b the value.
`timescale 1ns/1ps
module hbwu_cmp #(
  parameter hbwu_pkg::hbwu_kind_e KIND = hbwu_pkg::HBWU_INSTR
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [31:0]        ctrl,
  input  wire logic [31:0]        reg_a,
  input  wire logic [31:0]        reg_b,
  input  wire hbwu_pkg::hbwu_ev_s ev,
  output logic                    hit
);
  logic thr_ok;
  logic cond_a;
  logic cond_b;
  logic fire;
  logic kind_ok;

  always_comb begin
    thr_ok  = ctrl[hbwu_pkg::B_THR_LO + int'(ev.thread)];
    cond_a  = 1'b0;
    cond_b  = 1'b0;
    fire    = 1'b0;
    kind_ok = 1'b1;
    case (KIND)
      hbwu_pkg::HBWU_INSTR: begin
        cond_a = (ev.value == reg_a);
        fire   = ctrl[hbwu_pkg::B_SEL] ? !cond_a : cond_a;
      end
      hbwu_pkg::HBWU_DATA: begin
        cond_a  = (ev.value >= reg_a);
        cond_b  = (ev.value <= reg_b);
        fire    = ctrl[hbwu_pkg::B_SEL] ? (cond_a | cond_b) : (cond_a & cond_b);
        // Stores always qualify; loads only when the load bit is set.
        kind_ok = !ev.load | ctrl[hbwu_pkg::B_LOAD];
      end
      hbwu_pkg::HBWU_RES: begin
        cond_a = ((ev.value & reg_a) == (reg_b & reg_a));
        cond_b = !cond_a;
        fire   = ctrl[hbwu_pkg::B_SEL] ? cond_b : cond_a;
      end
      default: fire = 1'b0;
    endcase
    hit = ev.valid & ctrl[hbwu_pkg::B_EN] & thr_ok & kind_ok & fire;
  end

  a_enable_gates_hit: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl[hbwu_pkg::B_EN] |-> !hit) else $error("Disabled comparator fired.");
  a_thread_gates_hit: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl[hbwu_pkg::B_THR_LO + ev.thread] |-> !hit) else $error("Masked thread fired.");
  a_load_gate_data: assert property (@(posedge clk) disable iff (!rst_n)
    (KIND == hbwu_pkg::HBWU_DATA && ev.load && !ctrl[hbwu_pkg::B_LOAD]) |-> !hit)
    else $error("Load hit with loads disabled.");
endmodule : hbwu_cmp

// ### design/hbwu_top.sv
// Purpose: Hardware breakpoint, data watchpoint and resource watchpoint unit.
// Assumes: Pipeline events are synchronous to clk; registers over Avalon-MM.
// Notes:   Instruction hits outrank data hits, which outrank resource hits.
`timescale 1ns/1ps
module hbwu_top #(
  parameter int NTHREADS = 8
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [9:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire hbwu_pkg::hbwu_ev_s ins_ev,
  input  wire hbwu_pkg::hbwu_ev_s mem_ev,
  input  wire hbwu_pkg::hbwu_ev_s res_ev,
  output logic                    dbg_irq
);
  localparam int NS = hbwu_pkg::NSLOT;

  if (NTHREADS < 1 || NTHREADS > hbwu_pkg::MAX_THR) begin : g_bad_nthreads
    $error("NTHREADS must lie between 1 and 8.");
  end

  // Thread enable bits above the thread count never store a one.
  localparam logic [31:0] THR_KEEP =
    ~(32'((({hbwu_pkg::MAX_THR{1'b1}} << NTHREADS) & 8'hFF)) << hbwu_pkg::B_THR_LO);

  logic [31:0] ib_addr_r [NS];
  logic [31:0] ib_ctrl_r [NS];
  logic [31:0] dw_a1_r   [NS];
  logic [31:0] dw_a2_r   [NS];
  logic [31:0] dw_ctrl_r [NS];
  logic [31:0] rw_mask_r [NS];
  logic [31:0] rw_val_r  [NS];
  logic [31:0] rw_ctrl_r [NS];
  logic [31:0] dbg_ty_r;
  logic [31:0] dbg_dat_r;
  logic [31:0] avs_readdata_nxt;
  logic [NS-1:0] ib_hit;
  logic [NS-1:0] dw_hit;
  logic [NS-1:0] rw_hit;
  hbwu_pkg::hbwu_bus_e bus_r;
  logic [7:0] idx;
  logic [1:0] slot;
  logic       wr_take;

  function automatic logic [1:0] lowest(input logic [NS-1:0] v);
    logic [1:0] n;
    n = 2'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = 2'(i);
      end
    end
    return n;
  endfunction : lowest

  function automatic logic in_bank(input logic [7:0] i, input logic [7:0] base);
    return i[7:2] == base[7:2];
  endfunction : in_bank

  assign idx     = avs_address[9:2];
  assign slot    = idx[1:0];
  // A write takes effect at the edge where the master sees waitrequest low.
  assign wr_take = avs_write && (bus_r == hbwu_pkg::BUS_ACK);

  // Bus handshake: one wait cycle, then waitrequest low for exactly one cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_r           <= hbwu_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_r)
        hbwu_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_r           <= hbwu_pkg::BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        hbwu_pkg::BUS_ACK: begin
          bus_r           <= hbwu_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_r           <= hbwu_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Unmapped indices read as zero; reserved control bits read as zero.
  always_comb begin
    avs_readdata_nxt = 32'h0000_0000;
    if (in_bank(idx, hbwu_pkg::IDX_IB_ADDR)) begin
      avs_readdata_nxt = ib_addr_r[slot];
    end else if (in_bank(idx, hbwu_pkg::IDX_IB_CTRL)) begin
      avs_readdata_nxt = ib_ctrl_r[slot];
    end else if (in_bank(idx, hbwu_pkg::IDX_DW_A1)) begin
      avs_readdata_nxt = dw_a1_r[slot];
    end else if (in_bank(idx, hbwu_pkg::IDX_DW_A2)) begin
      avs_readdata_nxt = dw_a2_r[slot];
    end else if (in_bank(idx, hbwu_pkg::IDX_DW_CTRL)) begin
      avs_readdata_nxt = dw_ctrl_r[slot];
    end else if (in_bank(idx, hbwu_pkg::IDX_RW_MASK)) begin
      avs_readdata_nxt = rw_mask_r[slot];
    end else if (in_bank(idx, hbwu_pkg::IDX_RW_VAL)) begin
      avs_readdata_nxt = rw_val_r[slot];
    end else if (in_bank(idx, hbwu_pkg::IDX_RW_CTRL)) begin
      avs_readdata_nxt = rw_ctrl_r[slot];
    end else if (idx == hbwu_pkg::IDX_DBG_TY) begin
      avs_readdata_nxt = dbg_ty_r;
    end else if (idx == hbwu_pkg::IDX_DBG_DAT) begin
      avs_readdata_nxt = dbg_dat_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_r == hbwu_pkg::BUS_IDLE) begin
      avs_readdata <= avs_readdata_nxt;
    end
  end

  // Configuration banks, one slot per comparator.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NS; i++) begin
        ib_addr_r[i] <= 32'h0000_0000;
        ib_ctrl_r[i] <= hbwu_pkg::RST_CTRL;
        dw_a1_r[i]   <= 32'h0000_0000;
        dw_a2_r[i]   <= 32'h0000_0000;
        dw_ctrl_r[i] <= hbwu_pkg::RST_CTRL;
        rw_mask_r[i] <= 32'h0000_0000;
        rw_val_r[i]  <= 32'h0000_0000;
        rw_ctrl_r[i] <= hbwu_pkg::RST_CTRL;
      end
    end else if (wr_take) begin
      if (in_bank(idx, hbwu_pkg::IDX_IB_ADDR)) begin
        ib_addr_r[slot] <= avs_writedata;
      end
      if (in_bank(idx, hbwu_pkg::IDX_IB_CTRL)) begin
        ib_ctrl_r[slot] <= avs_writedata & hbwu_pkg::MASK_IB_CTRL & THR_KEEP;
      end
      if (in_bank(idx, hbwu_pkg::IDX_DW_A1)) begin
        dw_a1_r[slot] <= avs_writedata;
      end
      if (in_bank(idx, hbwu_pkg::IDX_DW_A2)) begin
        dw_a2_r[slot] <= avs_writedata;
      end
      if (in_bank(idx, hbwu_pkg::IDX_DW_CTRL)) begin
        dw_ctrl_r[slot] <= avs_writedata & hbwu_pkg::MASK_DW_CTRL & THR_KEEP;
      end
      if (in_bank(idx, hbwu_pkg::IDX_RW_MASK)) begin
        rw_mask_r[slot] <= avs_writedata;
      end
      if (in_bank(idx, hbwu_pkg::IDX_RW_VAL)) begin
        rw_val_r[slot] <= avs_writedata;
      end
      if (in_bank(idx, hbwu_pkg::IDX_RW_CTRL)) begin
        rw_ctrl_r[slot] <= avs_writedata & hbwu_pkg::MASK_RW_CTRL & THR_KEEP;
      end
    end
  end

  for (genvar g = 0; g < NS; g++) begin : g_cmp
    hbwu_cmp #(.KIND(hbwu_pkg::HBWU_INSTR)) u_ib (
      .clk   (clk),
      .rst_n (rst_n),
      .ctrl  (ib_ctrl_r[g]),
      .reg_a (ib_addr_r[g]),
      .reg_b (ib_addr_r[g]),
      .ev    (ins_ev),
      .hit   (ib_hit[g])
    );
    hbwu_cmp #(.KIND(hbwu_pkg::HBWU_DATA)) u_dw (
      .clk   (clk),
      .rst_n (rst_n),
      .ctrl  (dw_ctrl_r[g]),
      .reg_a (dw_a1_r[g]),
      .reg_b (dw_a2_r[g]),
      .ev    (mem_ev),
      .hit   (dw_hit[g])
    );
    hbwu_cmp #(.KIND(hbwu_pkg::HBWU_RES)) u_rw (
      .clk   (clk),
      .rst_n (rst_n),
      .ctrl  (rw_ctrl_r[g]),
      .reg_a (rw_mask_r[g]),
      .reg_b (rw_val_r[g]),
      .ev    (res_ev),
      .hit   (rw_hit[g])
    );
  end

  // The interrupt is a one-cycle request toward the core per triggering cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_irq <= 1'b0;
    end else begin
      dbg_irq <= |{ib_hit, dw_hit, rw_hit};
    end
  end

  // Cause capture. A hit wins over a software write in the same cycle, so an
  // event is never lost to a debugger clearing the record.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_ty_r <= 32'h0000_0000;
    end else if (|ib_hit) begin
      dbg_ty_r <= {14'h0000, lowest(ib_hit), 8'(ins_ev.thread), 5'h00,
                   hbwu_pkg::CAUSE_IB};
    end else if (|dw_hit) begin
      dbg_ty_r <= {14'h0000, lowest(dw_hit), 8'(mem_ev.thread), 5'h00,
                   hbwu_pkg::CAUSE_DW};
    end else if (|rw_hit) begin
      dbg_ty_r <= {14'h0000, lowest(rw_hit), 8'(res_ev.thread), 5'h00,
                   hbwu_pkg::CAUSE_RW};
    end else if (wr_take && idx == hbwu_pkg::IDX_DBG_TY) begin
      dbg_ty_r <= avs_writedata & hbwu_pkg::MASK_DBG_TY;
    end
  end

  // Instruction hits leave the data record alone, as they carry no operand.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_dat_r <= 32'h0000_0000;
    end else if (|ib_hit) begin
      dbg_dat_r <= dbg_dat_r;
    end else if (|dw_hit) begin
      dbg_dat_r <= mem_ev.value;
    end else if (|rw_hit) begin
      dbg_dat_r <= res_ev.value;
    end else if (wr_take && idx == hbwu_pkg::IDX_DBG_DAT) begin
      dbg_dat_r <= avs_writedata;
    end
  end

  a_instr_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (ins_ev.valid && ib_ctrl_r[0][hbwu_pkg::B_EN] && !ib_ctrl_r[0][hbwu_pkg::B_SEL]
     && ib_ctrl_r[0][hbwu_pkg::B_THR_LO + ins_ev.thread] && ins_ev.value == ib_addr_r[0])
    |=> dbg_irq) else $error("Equal PC did not raise the interrupt.");
  a_instr_cause: assert property (@(posedge clk) disable iff (!rst_n)
    (|ib_hit) |=> dbg_ty_r[2:0] == 3'h3) else $error("Instruction cause not 3.");
  a_data_cause: assert property (@(posedge clk) disable iff (!rst_n)
    (!(|ib_hit) && (|dw_hit)) |=> dbg_ty_r[2:0] == 3'h4 && dbg_dat_r == $past(mem_ev.value))
    else $error("Data hit record wrong.");
  a_res_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (!(|ib_hit) && !(|dw_hit) && (|rw_hit))
    |=> dbg_ty_r[2:0] == 3'h5 && dbg_dat_r == $past(res_ev.value))
    else $error("Resource hit record wrong.");
  a_lowest_slot: assert property (@(posedge clk) disable iff (!rst_n)
    ib_hit[0] |=> dbg_ty_r[17:16] == 2'h0 &&
    dbg_ty_r[15:8] == 8'($past(ins_ev.thread))) else $error("Not lowest slot.");
  a_no_irq_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !(|{ib_hit, dw_hit, rw_hit}) |=> !dbg_irq) else $error("Spurious interrupt.");
  a_wait_one: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_r == hbwu_pkg::BUS_IDLE && (avs_read || avs_write))
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("Wait cycle count wrong.");
  a_first_addr_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_take && in_bank(idx, hbwu_pkg::IDX_DW_A1)) |=> dw_a1_r[$past(slot)] ==
    $past(avs_writedata)) else $error("First address not stored.");
endmodule : hbwu_top

// ### tb/hbwu_pipe_model.sv
// Purpose: Pipeline stand-in issuing instruction, memory and resource events.
// Assumes: Events change right after a rising edge and last exactly one cycle.
// Notes:   Idle streams show the inverted last word, so stale data can never match.
`timescale 1ns/1ps
module hbwu_pipe_model (
  input  wire logic          clk,
  output hbwu_pkg::hbwu_ev_s ins_ev,
  output hbwu_pkg::hbwu_ev_s mem_ev,
  output hbwu_pkg::hbwu_ev_s res_ev
);
  initial begin
    ins_ev = '0;
    mem_ev = '0;
    res_ev = '0;
  end

  // Bit 0 of which selects the instruction stream, bit 1 memory, bit 2 resource.
  task automatic issue(input logic [2:0] which, input logic [2:0] thr,
                       input logic [31:0] val, input logic ld);
    hbwu_pkg::hbwu_ev_s ev;
    ev = '{valid: 1'b1, load: ld, thread: thr, value: val};
    @(posedge clk);
    if (which[0]) ins_ev <= ev;
    if (which[1]) mem_ev <= ev;
    if (which[2]) res_ev <= ev;
    @(posedge clk);
    ins_ev <= {1'b0, ~ins_ev[35:0]};
    mem_ev <= {1'b0, ~mem_ev[35:0]};
    res_ev <= {1'b0, ~res_ev[35:0]};
  endtask : issue
endmodule : hbwu_pipe_model

// ### tb/hbwu_top_tb.sv
// Purpose: Self-checking bench for the breakpoint and watchpoint unit.
// Assumes: One wait state per Avalon access; a hit shows on dbg_irq one cycle later.
// Notes:   Expected type words are built from cause, comparator number and thread.
`timescale 1ns/1ps
module hbwu_top_tb;
  logic               clk;
  logic               rst_n;
  logic [9:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  hbwu_pkg::hbwu_ev_s ins_ev;
  hbwu_pkg::hbwu_ev_s mem_ev;
  hbwu_pkg::hbwu_ev_s res_ev;
  logic               dbg_irq;
  int                 err_total;
  int                 n_checks;
  logic [7:0]         banks [5];

  always #12.5 clk = ~clk;

  hbwu_top #(.NTHREADS(8)) i_hbwu_top (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ins_ev(ins_ev), .mem_ev(mem_ev),
    .res_ev(res_ev), .dbg_irq(dbg_irq));

  hbwu_pipe_model i_hbwu_pipe_model (
    .clk(clk), .ins_ev(ins_ev), .mem_ev(mem_ev), .res_ev(res_ev));

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Request is held until waitrequest is sampled low; read data are taken at that edge.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    // Only the watchdog ends a wait that never completes.
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0000_0000, q);
    chk(what, exp, q);
  endtask : rdchk

  task automatic fire(input logic [2:0] which, input logic [2:0] thr,
                      input logic [31:0] val, input logic ld, input logic exp);
    i_hbwu_pipe_model.issue(which, thr, val, ld);
    #1;
    chk("dbg_irq", {31'b0, exp}, {31'b0, dbg_irq});
  endtask : fire

  initial begin
    #200_000;
    err_total++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    err_total = 0;
    n_checks = 0;
    banks = '{hbwu_pkg::IDX_IB_ADDR, hbwu_pkg::IDX_DW_A1, hbwu_pkg::IDX_DW_A2,
              hbwu_pkg::IDX_RW_MASK, hbwu_pkg::IDX_RW_VAL};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      rdchk("ib_ctrl", hbwu_pkg::IDX_IB_CTRL + 8'(s), hbwu_pkg::RST_CTRL);
      rdchk("dw_ctrl", hbwu_pkg::IDX_DW_CTRL + 8'(s), hbwu_pkg::RST_CTRL);
      rdchk("rw_ctrl", hbwu_pkg::IDX_RW_CTRL + 8'(s), hbwu_pkg::RST_CTRL);
    end
    wr(8'h00, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h00, 32'h0000_0000);
    // Every address, mask and value bank slot gets a distinct word, so any aliasing shows on readback.
    for (int b = 0; b < 5; b++)
      for (int s = 0; s < 4; s++) wr(banks[b] + 8'(s), {banks[b], 16'h5A00, 8'(s)});
    for (int b = 0; b < 5; b++)
      for (int s = 0; s < 4; s++)
        rdchk("bank", banks[b] + 8'(s), {banks[b], 16'h5A00, 8'(s)});
    wr(hbwu_pkg::IDX_IB_CTRL + 8'h03, 32'hFFFF_FFFF);
    wr(hbwu_pkg::IDX_DW_CTRL + 8'h03, 32'hFFFF_FFFF);
    wr(hbwu_pkg::IDX_RW_CTRL + 8'h03, 32'hFFFF_FFFF);
    rdchk("ib_ctrl_rsv", hbwu_pkg::IDX_IB_CTRL + 8'h03, 32'h00FF_0003);
    rdchk("dw_ctrl_rsv", hbwu_pkg::IDX_DW_CTRL + 8'h03, 32'h00FF_0007);
    rdchk("rw_ctrl_rsv", hbwu_pkg::IDX_RW_CTRL + 8'h03, 32'h00FF_0003);
    wr(hbwu_pkg::IDX_IB_CTRL + 8'h03, 32'h0000_0000);
    wr(hbwu_pkg::IDX_DW_CTRL + 8'h03, 32'h0000_0000);
    wr(hbwu_pkg::IDX_RW_CTRL + 8'h03, 32'h0000_0000);
    // Instruction slot 2, thread 1 only.
    wr(hbwu_pkg::IDX_IB_ADDR + 8'h02, 32'h0000_1040);
    wr(hbwu_pkg::IDX_IB_CTRL + 8'h02, 32'h0002_0000);
    fire(3'b001, 3'd1, 32'h0000_1040, 1'b0, 1'b0);
    wr(hbwu_pkg::IDX_IB_CTRL + 8'h02, 32'h0002_0001);
    fire(3'b001, 3'd1, 32'h0000_1040, 1'b0, 1'b1);
    rdchk("type", hbwu_pkg::IDX_DBG_TY, 32'h0002_0103);
    fire(3'b001, 3'd2, 32'h0000_1040, 1'b0, 1'b0);
    fire(3'b001, 3'd1, 32'h0000_1044, 1'b0, 1'b0);
    wr(hbwu_pkg::IDX_IB_CTRL + 8'h02, 32'h0002_0003);
    fire(3'b001, 3'd1, 32'h0000_1044, 1'b0, 1'b1);
    fire(3'b001, 3'd1, 32'h0000_1040, 1'b0, 1'b0);
    wr(hbwu_pkg::IDX_IB_CTRL + 8'h02, 32'h0002_0001);
    wr(hbwu_pkg::IDX_IB_ADDR, 32'h0000_1040);
    wr(hbwu_pkg::IDX_IB_CTRL, 32'h0002_0001);
    fire(3'b001, 3'd1, 32'h0000_1040, 1'b0, 1'b1);
    rdchk("type", hbwu_pkg::IDX_DBG_TY, 32'h0000_0103);
    wr(hbwu_pkg::IDX_IB_CTRL, 32'h0000_0000);
    wr(hbwu_pkg::IDX_IB_CTRL + 8'h02, 32'h0000_0000);
    // Data slot 1, window 0x100..0x1FF, thread 3, both conditions required.
    wr(hbwu_pkg::IDX_DW_A1 + 8'h01, 32'h0000_0100);
    wr(hbwu_pkg::IDX_DW_A2 + 8'h01, 32'h0000_01FF);
    wr(hbwu_pkg::IDX_DW_CTRL + 8'h01, 32'h0008_0001);
    fire(3'b010, 3'd3, 32'h0000_0180, 1'b0, 1'b1);
    rdchk("type", hbwu_pkg::IDX_DBG_TY, 32'h0001_0304);
    rdchk("data", hbwu_pkg::IDX_DBG_DAT, 32'h0000_0180);
    fire(3'b010, 3'd3, 32'h0000_0180, 1'b1, 1'b0);
    fire(3'b010, 3'd3, 32'h0000_0300, 1'b0, 1'b0);
    wr(hbwu_pkg::IDX_DW_CTRL + 8'h01, 32'h0008_0005);
    fire(3'b010, 3'd3, 32'h0000_0180, 1'b1, 1'b1);
    wr(hbwu_pkg::IDX_DW_CTRL + 8'h01, 32'h0008_0003);
    fire(3'b010, 3'd3, 32'h0000_0300, 1'b0, 1'b1);
    fire(3'b010, 3'd3, 32'h0000_00FF, 1'b0, 1'b1);
    wr(hbwu_pkg::IDX_DW_CTRL + 8'h01, 32'h0000_0000);
    // Resource slot 3, low byte must equal 0x42, thread 0.
    wr(hbwu_pkg::IDX_RW_MASK + 8'h03, 32'h0000_00FF);
    wr(hbwu_pkg::IDX_RW_VAL + 8'h03, 32'h0000_0042);
    wr(hbwu_pkg::IDX_RW_CTRL + 8'h03, 32'h0001_0001);
    fire(3'b100, 3'd0, 32'h0000_1242, 1'b0, 1'b1);
    rdchk("type", hbwu_pkg::IDX_DBG_TY, 32'h0003_0005);
    rdchk("data", hbwu_pkg::IDX_DBG_DAT, 32'h0000_1242);
    fire(3'b100, 3'd0, 32'h0000_1243, 1'b0, 1'b0);
    wr(hbwu_pkg::IDX_RW_CTRL + 8'h03, 32'h0001_0003);
    fire(3'b100, 3'd0, 32'h0000_1243, 1'b0, 1'b1);
    fire(3'b100, 3'd0, 32'h0000_0042, 1'b0, 1'b0);
    // Same-cycle instruction and resource hits: the instruction hit is recorded.
    wr(hbwu_pkg::IDX_IB_ADDR + 8'h01, 32'h0000_7777);
    wr(hbwu_pkg::IDX_IB_CTRL + 8'h01, 32'h0001_0001);
    fire(3'b101, 3'd0, 32'h0000_7777, 1'b0, 1'b1);
    rdchk("type", hbwu_pkg::IDX_DBG_TY, 32'h0001_0003);
    // The instruction hit carries no operand, so the last resource id stays.
    rdchk("data", hbwu_pkg::IDX_DBG_DAT, 32'h0000_1243);
    wr(hbwu_pkg::IDX_DBG_TY, 32'hFFFF_FFFF);
    rdchk("type_wr", hbwu_pkg::IDX_DBG_TY, hbwu_pkg::MASK_DBG_TY);
    wr(hbwu_pkg::IDX_DBG_DAT, 32'h1234_5678);
    rdchk("data_wr", hbwu_pkg::IDX_DBG_DAT, 32'h1234_5678);
    // A second reset mid-run must clear every enable and the record.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ib_ctrl_rst", hbwu_pkg::IDX_IB_CTRL + 8'h01, hbwu_pkg::RST_CTRL);
    rdchk("rw_ctrl_rst", hbwu_pkg::IDX_RW_CTRL + 8'h03, hbwu_pkg::RST_CTRL);
    rdchk("type_rst", hbwu_pkg::IDX_DBG_TY, 32'h0000_0000);
    fire(3'b101, 3'd0, 32'h0000_7777, 1'b0, 1'b0);
    test_done();
  end
endmodule : hbwu_top_tb
